// >>> shared/s2mmc_pkg.sv
// Constants and types of the stream-to-memory channel control block
// Notes on behaviour
// - Run/stop written 0 stops the channel once operations in progress complete.
// - Scatter-gather stop flushes work but lets queued descriptor updates finish first.
// - Simple-mode stop flushes work and may end streams early; data not guaranteed.
// - Halted flag goes to 1 once the engine has really halted after stop.
// - Hardware clears run/stop by itself when a channel error occurs.
// - Run/stop written 1 starts operation; halted goes to 0 when it begins.
// - Control bit 1 ignores writes and always reads 1.
// - Writing 1 to soft reset bit 2 starts a graceful whole-core reset.
// - Outgoing stream transfers cut short by soft reset end with last marker.
// - Soft reset from either channel resets the entire engine.
// - After soft reset every register and bit holds its reset value.
// - Soft reset bit reads 1 during a reset, 0 otherwise.
// - Control bits 3 to 11 ignore writes and read zero.
package s2mmc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] CTRL_OFFSET = 8'h30;
  localparam logic [7:0] STAT_OFFSET = 8'h34;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned RUN_STOP_BIT = 0;
  localparam int unsigned RSVD_ONE_BIT = 1;
  localparam int unsigned SOFT_RESET_BIT = 2;
  localparam int unsigned RSVD_ZERO_LO = 3;
  localparam int unsigned RSVD_ZERO_HI = 11;
  localparam int unsigned HALTED_BIT = 0;
  localparam logic RUN_STOP_RST = 1'h0;
  localparam logic SOFT_RESET_RST = 1'h0;
  localparam logic HALTED_RST = 1'h1;
  localparam logic RSVD_ONE_VAL = 1'h1;

  // ----------------------------------------------------------------
  // Bus answers and buffer
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  typedef enum logic [1:0] {ST_HALTED, ST_RUNNING, ST_STOPPING, ST_RESETTING} s2mmc_state_t;

endpackage

// >>> src/s2mmc_buf2.sv
// Two-entry data buffer between the stream intake and the memory write port
`timescale 1ns/10ps
module s2mmc_buf2
  import s2mmc_pkg::*;
(
  input wire logic clk_i,                   // Clock
  input wire logic arst_n_i,                // Async reset, active low
  input wire logic in_en_i,                 // Intake allowed from next cycle
  input wire logic [DATA_W-1:0] in_data_i,  // Incoming word
  input wire logic in_last_i,               // Incoming last marker
  input wire logic in_valid_i,              // Incoming word valid
  output logic in_ready_o,                  // Room for a word
  input wire logic force_last_i,            // Close the buffered packet
  output logic [DATA_W-1:0] out_data_o,     // Head word
  output logic out_last_o,                  // Head last marker
  output logic out_valid_o,                 // Head word valid
  input wire logic out_ready_i,             // Drain side takes the head
  output logic [1:0] level_o                // Words held
);

  logic [DATA_W-1:0] dat_q [2];
  logic lst_q [2];
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic rdy_q;
  logic vld_q;
  logic push;
  logic pop;
  logic wr_idx;
  logic tail_idx;

  assign push = in_valid_i & rdy_q;
  assign pop = vld_q & out_ready_i;
  assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  assign wr_idx = cnt_q[0] ^ pop;
  assign tail_idx = cnt_d[1];

  // ----------------------------------------------------------------
  // Occupancy and handshake flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_q <= 2'h0;
      rdy_q <= 1'h0;
      vld_q <= 1'h0;
    end
    else
    begin
      cnt_q <= cnt_d;
      rdy_q <= in_en_i & (cnt_d < BUF_DEPTH);
      vld_q <= (cnt_d != 2'h0);
    end
  end

  // ----------------------------------------------------------------
  // Storage: head shifts on pop, tail closed on request
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dat_q[0] <= '0;
      dat_q[1] <= '0;
      lst_q[0] <= 1'h0;
      lst_q[1] <= 1'h0;
    end
    else
    begin
      if (pop)
      begin
        dat_q[0] <= dat_q[1];
        lst_q[0] <= lst_q[1];
      end
      if (push)
      begin
        dat_q[wr_idx] <= in_data_i;
        lst_q[wr_idx] <= in_last_i | force_last_i;
      end
      else if (force_last_i && cnt_d != 2'h0)
      begin
        lst_q[tail_idx] <= 1'h1;
      end
    end
  end

  assign in_ready_o = rdy_q;
  assign out_valid_o = vld_q;
  assign out_data_o = dat_q[0];
  assign out_last_o = lst_q[0];
  assign level_o = cnt_q;

endmodule

// >>> src/s2mmc_top.sv
// Stream-to-memory channel control: register slave, run/stop and soft reset sequencing
`timescale 1ns/10ps
module s2mmc_top
  import s2mmc_pkg::*;
#(
  parameter bit SCATTER_GATHER_OPTION = 1'b1
)
(
  input wire logic clk_i,                        // Clock, 100 MHz
  input wire logic arst_n_i,                     // Async reset, active low
  input wire logic [ADDR_W-1:0] s_axil_awaddr_i, // Write address
  input wire logic s_axil_awvalid_i,             // Write address valid
  output logic s_axil_awready_o,                 // Write address ready
  input wire logic [DATA_W-1:0] s_axil_wdata_i,  // Write data
  input wire logic [3:0] s_axil_wstrb_i,         // Write byte strobes
  input wire logic s_axil_wvalid_i,              // Write data valid
  output logic s_axil_wready_o,                  // Write data ready
  output logic [1:0] s_axil_bresp_o,             // Write response
  output logic s_axil_bvalid_o,                  // Write response valid
  input wire logic s_axil_bready_i,              // Write response ready
  input wire logic [ADDR_W-1:0] s_axil_araddr_i, // Read address
  input wire logic s_axil_arvalid_i,             // Read address valid
  output logic s_axil_arready_o,                 // Read address ready
  output logic [DATA_W-1:0] s_axil_rdata_o,      // Read data
  output logic [1:0] s_axil_rresp_o,             // Read response
  output logic s_axil_rvalid_o,                  // Read data valid
  input wire logic s_axil_rready_i,              // Read data ready
  input wire logic [DATA_W-1:0] s_axis_tdata_i,  // Stream data in
  input wire logic s_axis_tlast_i,               // Stream last in
  input wire logic s_axis_tvalid_i,              // Stream valid in
  output logic s_axis_tready_o,                  // Stream ready out
  output logic [DATA_W-1:0] mem_wdata_o,         // Memory write data
  output logic mem_wlast_o,                      // Memory write last beat
  output logic mem_wvalid_o,                     // Memory write valid
  input wire logic mem_wready_i,                 // Memory write ready
  input wire logic mem_busy_i,                   // Memory writes outstanding
  input wire logic desc_upd_pending_i,           // Descriptor updates queued
  input wire logic chan_err_i,                   // Channel error pulse
  input wire logic peer_soft_reset_i,            // Other channel asks soft reset
  output logic halted_o,                         // Channel halted
  output logic soft_reset_o                      // Engine-wide soft reset active
);

  s2mmc_state_t state_q;
  s2mmc_state_t state_d;
  logic run_stop_q;
  logic soft_reset_q;
  logic halted_q;
  logic wr_rdy_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rd_rdy_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rd_word;
  logic wr_fire;
  logic rd_fire;
  logic wr_ctrl_hit;
  logic wr_stat_hit;
  logic rd_ctrl_hit;
  logic rd_stat_hit;
  logic ctrl_wr;
  logic drained;
  logic reset_done;
  logic [1:0] buf_level;

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  assign wr_fire = wr_rdy_q & s_axil_awvalid_i & s_axil_wvalid_i;
  assign rd_fire = rd_rdy_q & s_axil_arvalid_i;
  assign wr_ctrl_hit = (s_axil_awaddr_i[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2]);
  assign wr_stat_hit = (s_axil_awaddr_i[ADDR_W-1:2] == STAT_OFFSET[ADDR_W-1:2]);
  assign rd_ctrl_hit = (s_axil_araddr_i[ADDR_W-1:2] == CTRL_OFFSET[ADDR_W-1:2]);
  assign rd_stat_hit = (s_axil_araddr_i[ADDR_W-1:2] == STAT_OFFSET[ADDR_W-1:2]);
  assign ctrl_wr = wr_fire & wr_ctrl_hit & s_axil_wstrb_i[0];

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_rdy_q <= 1'h0;
      bvalid_q <= 1'h0;
      bresp_q <= RESP_OKAY;
    end
    else
    begin
      wr_rdy_q <= s_axil_awvalid_i & s_axil_wvalid_i & ~wr_rdy_q & ~bvalid_q;
      if (wr_fire)
      begin
        bvalid_q <= 1'h1;
        bresp_q <= (wr_ctrl_hit | wr_stat_hit) ? RESP_OKAY : RESP_DECERR;
      end
      else if (s_axil_bready_i)
      begin
        bvalid_q <= 1'h0;
      end
    end
  end

  // Reserved one, reserved zeros, reset status
  always_comb
  begin
    rd_word = '0;
    if (rd_ctrl_hit)
    begin
      rd_word[RUN_STOP_BIT] = run_stop_q;
      rd_word[RSVD_ONE_BIT] = RSVD_ONE_VAL;
      rd_word[SOFT_RESET_BIT] = soft_reset_q;
    end
    else if (rd_stat_hit)
    begin
      rd_word[HALTED_BIT] = halted_q;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rd_rdy_q <= 1'h0;
      rvalid_q <= 1'h0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
    end
    else
    begin
      rd_rdy_q <= s_axil_arvalid_i & ~rd_rdy_q & ~rvalid_q;
      if (rd_fire)
      begin
        rvalid_q <= 1'h1;
        rdata_q <= rd_word;
        rresp_q <= (rd_ctrl_hit | rd_stat_hit) ? RESP_OKAY : RESP_DECERR;
      end
      else if (s_axil_rready_i)
      begin
        rvalid_q <= 1'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel sequencing
  // ----------------------------------------------------------------
  // Descriptor updates must land; simple mode ignores them
  assign drained = (buf_level == 2'h0) & ~mem_busy_i
                 & ~(SCATTER_GATHER_OPTION & desc_upd_pending_i);
  assign reset_done = (state_q == ST_RESETTING) & drained;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_HALTED:
      begin
        if (run_stop_q)
        begin
          state_d = ST_RUNNING;
        end
      end
      ST_RUNNING:
      begin
        if (!run_stop_q)
        begin
          state_d = ST_STOPPING;
        end
      end
      ST_STOPPING:
      begin
        // Halt only once work in flight is done
        if (drained)
        begin
          state_d = ST_HALTED;
        end
      end
      ST_RESETTING:
      begin
        if (drained)
        begin
          state_d = ST_HALTED;
        end
      end
    endcase
    // Either channel's request resets the whole engine
    if (soft_reset_q && state_q != ST_RESETTING)
    begin
      state_d = ST_RESETTING;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_q <= ST_HALTED;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Run/stop: error clear outranks a software set in the same cycle
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      run_stop_q <= RUN_STOP_RST;
    end
    else if (reset_done)
    begin
      run_stop_q <= RUN_STOP_RST;
    end
    else if (chan_err_i)
    begin
      run_stop_q <= 1'h0;
    end
    else if (ctrl_wr && !soft_reset_q && !s_axil_wdata_i[SOFT_RESET_BIT])
    begin
      run_stop_q <= s_axil_wdata_i[RUN_STOP_BIT];
    end
  end

  // Soft reset request: a new request beats the self clear
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      soft_reset_q <= SOFT_RESET_RST;
    end
    // start graceful reset, from either channel
    else if ((ctrl_wr && s_axil_wdata_i[SOFT_RESET_BIT]) || peer_soft_reset_i)
    begin
      soft_reset_q <= 1'h1;
    end
    // self clear at end of sequence
    else if (reset_done)
    begin
      soft_reset_q <= SOFT_RESET_RST;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      halted_q <= HALTED_RST;
    end
    else if (state_d == ST_HALTED && state_q != ST_HALTED)
    begin
      halted_q <= 1'h1;
    end
    else if (state_d == ST_RUNNING && state_q == ST_HALTED)
    begin
      halted_q <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // Data path
  // ----------------------------------------------------------------
  // Stop or reset closes buffered packet with last marker
  s2mmc_buf2 u_buf (
    .clk_i        (clk_i),
    .arst_n_i     (arst_n_i),
    .in_en_i      (state_d == ST_RUNNING),
    .in_data_i    (s_axis_tdata_i),
    .in_last_i    (s_axis_tlast_i),
    .in_valid_i   (s_axis_tvalid_i),
    .in_ready_o   (s_axis_tready_o),
    .force_last_i (state_d == ST_STOPPING || state_d == ST_RESETTING),
    .out_data_o   (mem_wdata_o),
    .out_last_o   (mem_wlast_o),
    .out_valid_o  (mem_wvalid_o),
    .out_ready_i  (mem_wready_i),
    .level_o      (buf_level)
  );

  assign s_axil_awready_o = wr_rdy_q;
  assign s_axil_wready_o = wr_rdy_q;
  assign s_axil_bvalid_o = bvalid_q;
  assign s_axil_bresp_o = bresp_q;
  assign s_axil_arready_o = rd_rdy_q;
  assign s_axil_rvalid_o = rvalid_q;
  assign s_axil_rresp_o = rresp_q;
  assign s_axil_rdata_o = rdata_q;
  assign halted_o = halted_q;
  assign soft_reset_o = soft_reset_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  property p_stop_waits;
    state_q == ST_STOPPING && !drained && !soft_reset_q |=> !halted_q && state_q == ST_STOPPING;
  endproperty
  a_stop_waits: assert property (p_stop_waits)
    else $error("channel halted before work drained");

  property p_sg_desc_done;
    SCATTER_GATHER_OPTION && $rose(halted_q) |-> !$past(desc_upd_pending_i);
  endproperty
  a_sg_desc_done: assert property (p_sg_desc_done)
    else $error("halted with descriptor updates pending");

  property p_simple_halt;
    !SCATTER_GATHER_OPTION && state_q == ST_STOPPING && buf_level == 2'h0 && !mem_busy_i
      && !soft_reset_q |=> halted_q;
  endproperty
  a_simple_halt: assert property (p_simple_halt)
    else $error("simple mode stop did not halt");

  property p_halt_set;
    state_q == ST_STOPPING && drained && !soft_reset_q |=> halted_q && state_q == ST_HALTED;
  endproperty
  a_halt_set: assert property (p_halt_set)
    else $error("halted flag not set after stop");

  property p_err_clears;
    chan_err_i |=> !run_stop_q;
  endproperty
  a_err_clears: assert property (p_err_clears)
    else $error("run/stop not cleared by error");

  property p_run_start;
    state_q == ST_HALTED && run_stop_q && !soft_reset_q |=> !halted_q && state_q == ST_RUNNING;
  endproperty
  a_run_start: assert property (p_run_start)
    else $error("channel did not start on run");

  property p_rsvd_one;
    rd_fire && rd_ctrl_hit |=> s_axil_rvalid_o && s_axil_rdata_o[RSVD_ONE_BIT];
  endproperty
  a_rsvd_one: assert property (p_rsvd_one)
    else $error("reserved bit 1 did not read 1");

  property p_soft_start;
    ctrl_wr && s_axil_wdata_i[SOFT_RESET_BIT] |=> soft_reset_q ##1 state_q == ST_RESETTING;
  endproperty
  a_soft_start: assert property (p_soft_start)
    else $error("soft reset did not start");

  property p_cut_last;
    state_q == ST_RESETTING && mem_wvalid_o && buf_level == 2'h1 |-> mem_wlast_o;
  endproperty
  a_cut_last: assert property (p_cut_last)
    else $error("cut stream beat lacks last marker");

  property p_peer_reset;
    peer_soft_reset_i |=> soft_reset_q;
  endproperty
  a_peer_reset: assert property (p_peer_reset)
    else $error("peer soft reset ignored");

  property p_reset_values;
    reset_done && !peer_soft_reset_i && !(ctrl_wr && s_axil_wdata_i[SOFT_RESET_BIT])
      |=> !run_stop_q && halted_q && !soft_reset_q;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("registers not at reset values after soft reset");

  property p_reset_holds;
    soft_reset_q && !reset_done |=> soft_reset_q;
  endproperty
  a_reset_holds: assert property (p_reset_holds)
    else $error("soft reset bit dropped early");

  property p_rsvd_zero;
    rd_fire |=> s_axil_rdata_o[RSVD_ZERO_HI:RSVD_ZERO_LO] == '0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bits 3 to 11 not zero");

  property p_write_answer;
    wr_fire |=> s_axil_bvalid_o ##0 !s_axil_awready_o;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write not answered");

endmodule

// >>> verif/s2mmc_partner.sv
// Stream source and memory write sink facing the channel
`timescale 1ns/10ps
module s2mmc_partner
  import s2mmc_pkg::*;
(
  input wire logic clk_i,             // Clock
  input wire logic arst_n_i,          // Async reset, active low
  input wire logic go_i,              // Offer stream words
  input wire logic stall_i,           // Memory holds off writes
  input wire logic tready_i,          // Channel stream ready
  output logic [DATA_W-1:0] tdata_o,  // Stream word
  output logic tlast_o,               // Stream last
  output logic tvalid_o,              // Stream valid
  output logic wready_o               // Memory write ready
);
  logic [DATA_W-1:0] seq_q;
  logic [DATA_W-1:0] seq_d;

  assign seq_d = seq_q + {31'h0, tvalid_o & tready_i};

  // ----
  // Source: words count up, four to a packet, held until taken
  // ----
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      seq_q <= 32'h0;
      tvalid_o <= 1'b0;
      tdata_o <= 32'hFFFFFFFF;
      tlast_o <= 1'b0;
    end
    else
    begin
      seq_q <= seq_d;
      if (!tvalid_o || tready_i)
      begin
        tvalid_o <= go_i;
        // Released lines toggle so a stale word is never mistaken for data
        tdata_o <= go_i ? seq_d : ~tdata_o;
        tlast_o <= go_i ? (seq_d[1:0] == 2'h3) : ~tlast_o;
      end
    end
  end

  // Memory side may stall at will
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      wready_o <= 1'b0;
    else
      wready_o <= !stall_i;
  end
endmodule

// >>> verif/tb_s2mmc_top.sv
// Testbench of the stream-to-memory channel control block
`timescale 1ns/10ps
module tb_s2mmc_top;
  import s2mmc_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, tdata, mwdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, tlast, tvalid, tready;
  logic [1:0] bresp, rresp, wr_r, rd_r;
  logic mwlast, mwvalid, mwready, halted, srst, halted_s;
  logic go = 1'b0, stall = 1'b0, busy = 1'b0, pend = 1'b0, err = 1'b0, peer = 1'b0;
  logic [31:0] exp_word = 32'h0;
  logic last_q = 1'b0;
  int n_fail = 0;
  int checks = 0;

  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  s2mmc_top #(.SCATTER_GATHER_OPTION(1'b1)) u_dut (
    .clk_i(clk_i), .arst_n_i(arst_n),
    .s_axil_awaddr_i(awaddr), .s_axil_awvalid_i(awvalid), .s_axil_awready_o(awready),
    .s_axil_wdata_i(wdata), .s_axil_wstrb_i(wstrb), .s_axil_wvalid_i(wvalid),
    .s_axil_wready_o(wready), .s_axil_bresp_o(bresp), .s_axil_bvalid_o(bvalid),
    .s_axil_bready_i(bready), .s_axil_araddr_i(araddr), .s_axil_arvalid_i(arvalid),
    .s_axil_arready_o(arready), .s_axil_rdata_o(rdata), .s_axil_rresp_o(rresp),
    .s_axil_rvalid_o(rvalid), .s_axil_rready_i(rready),
    .s_axis_tdata_i(tdata), .s_axis_tlast_i(tlast), .s_axis_tvalid_i(tvalid),
    .s_axis_tready_o(tready), .mem_wdata_o(mwdata), .mem_wlast_o(mwlast),
    .mem_wvalid_o(mwvalid), .mem_wready_i(mwready), .mem_busy_i(busy),
    .desc_upd_pending_i(pend), .chan_err_i(err), .peer_soft_reset_i(peer),
    .halted_o(halted), .soft_reset_o(srst));

  // Simple-mode twin shares every input; only its halted flag is compared
  s2mmc_top #(.SCATTER_GATHER_OPTION(1'b0)) u_dut_simple (
    .clk_i(clk_i), .arst_n_i(arst_n),
    .s_axil_awaddr_i(awaddr), .s_axil_awvalid_i(awvalid), .s_axil_awready_o(),
    .s_axil_wdata_i(wdata), .s_axil_wstrb_i(wstrb), .s_axil_wvalid_i(wvalid),
    .s_axil_wready_o(), .s_axil_bresp_o(), .s_axil_bvalid_o(),
    .s_axil_bready_i(bready), .s_axil_araddr_i(araddr), .s_axil_arvalid_i(arvalid),
    .s_axil_arready_o(), .s_axil_rdata_o(), .s_axil_rresp_o(),
    .s_axil_rvalid_o(), .s_axil_rready_i(rready),
    .s_axis_tdata_i(tdata), .s_axis_tlast_i(tlast), .s_axis_tvalid_i(tvalid),
    .s_axis_tready_o(), .mem_wdata_o(), .mem_wlast_o(),
    .mem_wvalid_o(), .mem_wready_i(mwready), .mem_busy_i(busy),
    .desc_upd_pending_i(pend), .chan_err_i(err), .peer_soft_reset_i(peer),
    .halted_o(halted_s), .soft_reset_o());

  s2mmc_partner u_far (
    .clk_i(clk_i), .arst_n_i(arst_n), .go_i(go), .stall_i(stall), .tready_i(tready),
    .tdata_o(tdata), .tlast_o(tlast), .tvalid_o(tvalid), .wready_o(mwready));

  // ----
  // Checking and bus tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, m, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(negedge clk_i);
    awaddr = a;
    wdata = d;
    awvalid = 1'b1;
    wvalid = 1'b1;
    bready = 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (awready !== 1'b1 && n < 50);
    chk({31'h0, wready}, 32'h1, "write data ready");
    @(negedge clk_i);
    awvalid = 1'b0;
    wvalid = 1'b0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (bvalid !== 1'b1 && n < 50);
    wr_r = bresp;
    @(negedge clk_i);
    bready = 1'b0;
    chk(n < 50, 32'h1, "write stuck");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    int n;
    n = 0;
    @(negedge clk_i);
    araddr = a;
    arvalid = 1'b1;
    rready = 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (arready !== 1'b1 && n < 50);
    @(negedge clk_i);
    arvalid = 1'b0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (rvalid !== 1'b1 && n < 50);
    rd_r = rresp;
    chk(rdata, exp, "read data");
    @(negedge clk_i);
    rready = 1'b0;
  endtask

  // Waits a bounded time for halted (sel 0) or soft reset (sel 1) to reach v
  task automatic wt(input bit sel, input logic v, input int lim);
    int n;
    n = 0;
    while ((sel ? srst : halted) !== v && n < lim)
    begin
      @(negedge clk_i);
      n++;
    end
    chk({31'h0, sel ? srst : halted}, {31'h0, v}, "flag wait");
  endtask

  task automatic pulse_err(input bit sel);
    @(negedge clk_i);
    err = !sel;
    peer = sel;
    @(negedge clk_i);
    err = 1'b0;
    peer = 1'b0;
  endtask

  // Memory beats must arrive in stream order
  always @(posedge clk_i)
  begin
    if (mwvalid === 1'b1 && mwready === 1'b1)
    begin
      chk(mwdata, exp_word, "memory word order");
      exp_word <= exp_word + 32'h1;
      last_q <= mwlast;
    end
  end

  initial
  begin
    #60us;
    n_fail++;
    print_verdict();
  end

  // ----
  // Scenarios
  // ----
  initial
  begin
    repeat (5) @(negedge clk_i);
    arst_n = 1'b1;
    rd(CTRL_OFFSET, 32'h2);
    rd(STAT_OFFSET, 32'h1);
    wr(CTRL_OFFSET, 32'hFFFFFFF9);
    chk({30'h0, wr_r}, {30'h0, RESP_OKAY}, "mapped write");
    rd(CTRL_OFFSET, 32'h3);
    wt(1'b0, 1'b0, 5);
    stall = 1'b1;
    go = 1'b1;
    repeat (12) @(negedge clk_i);
    chk({31'h0, tready}, 32'h0, "full buffer refuses");
    pend = 1'b1;
    wr(CTRL_OFFSET, 32'h0);
    go = 1'b0;
    stall = 1'b0;
    repeat (10) @(negedge clk_i);
    chk({31'h0, halted}, 32'h0, "halt waits for descriptors");
    chk({31'h0, last_q}, 32'h1, "stop closes packet");
    chk({31'h0, halted_s}, 32'h1, "simple mode halts without descriptors");
    pend = 1'b0;
    wt(1'b0, 1'b1, 10);
    wr(CTRL_OFFSET, 32'h1);
    wt(1'b0, 1'b0, 5);
    pulse_err(1'b0);
    rd(CTRL_OFFSET, 32'h2);
    wt(1'b0, 1'b1, 10);
    wr(CTRL_OFFSET, 32'h1);
    stall = 1'b1;
    go = 1'b1;
    repeat (8) @(negedge clk_i);
    busy = 1'b1;
    wr(CTRL_OFFSET, 32'h4);
    go = 1'b0;
    rd(CTRL_OFFSET, 32'h7);
    stall = 1'b0;
    busy = 1'b0;
    wt(1'b1, 1'b0, 30);
    chk({31'h0, last_q}, 32'h1, "reset closes packet");
    rd(CTRL_OFFSET, 32'h2);
    rd(STAT_OFFSET, 32'h1);
    wr(CTRL_OFFSET, 32'h1);
    pulse_err(1'b1);
    wt(1'b1, 1'b1, 3);
    wt(1'b1, 1'b0, 30);
    rd(CTRL_OFFSET, 32'h2);
    wr(8'h40, 32'h1);
    chk({30'h0, wr_r}, {30'h0, RESP_DECERR}, "unmapped write");
    rd(8'h40, 32'h0);
    chk({30'h0, rd_r}, {30'h0, RESP_DECERR}, "unmapped read");
    print_verdict();
  end
endmodule
